/* File: bench/ush_engine_bench.sv */
// self-checking bench for the histogram engine
`default_nettype none
module ush_engine_bench
    import ush_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int          RLEN = 329;
    localparam logic [31:0] CTIME = 32'h5A5A0001, PIDX = 32'h00000007, SITE = 32'h61626300;
    localparam logic [47:0] NODE = 48'h0A1B2C3D4E5F;
    localparam logic [7:0]  RPORT = 8'h03;
    logic        clk, resetn, enable_wr, enable_val, enable_rd, timeout_wr, result_ready;
    logic        name_wr, name_wr_ok, name_inconsistent, odd_symmetry;
    logic        rec_last, rec_valid, rec_ready, sample_valid;
    logic [15:0] timeout_val, timeout_rd;
    logic [31:0] rec_data;
    logic [7:0]  sample_msb;
    ush_meas_t   measurement_state;
    logic [31:0] exp_hits[256];
    int          err_total = 0;
    int          samples_checked = 0;
    ush_engine #(.TICK_CYC(10), .NEAR_FULL(32'h00000040)) dut (
        .clk(clk), .resetn(resetn), .sample_msb(sample_msb), .sample_valid(sample_valid),
        .enable_wr(enable_wr), .enable_val(enable_val), .enable_rd(enable_rd),
        .timeout_wr(timeout_wr), .timeout_val(timeout_val), .timeout_rd(timeout_rd),
        .measurement_state(measurement_state), .result_ready(result_ready),
        .name_wr(name_wr), .name_wr_ok(name_wr_ok), .name_inconsistent(name_inconsistent),
        .odd_symmetry(odd_symmetry), .capture_time(CTIME), .port_index(PIDX),
        .remote_phy_node(NODE), .remote_port(RPORT), .site_id_word(SITE),
        .rec_data(rec_data), .rec_last(rec_last), .rec_valid(rec_valid), .rec_ready(rec_ready));
    ush_far_model far (
        .clk(clk), .rec_data(rec_data), .rec_last(rec_last), .rec_valid(rec_valid),
        .rec_ready(rec_ready), .sample_msb(sample_msb), .sample_valid(sample_valid));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_state(input ush_meas_t exp);
        cmp_word("state", {30'h0, exp}, {30'h0, measurement_state});
    endtask
    task automatic set_enable(input logic v);
        @(negedge clk);
        enable_wr = 1'b1;
        enable_val = v;
        @(negedge clk);
        enable_wr = 1'b0;
    endtask
    task automatic set_timeout(input logic [15:0] v);
        @(negedge clk);
        timeout_wr = 1'b1;
        timeout_val = v;
        @(negedge clk);
        timeout_wr = 1'b0;
    endtask
    task automatic name_try(input logic refused);
        @(negedge clk);
        name_wr = 1'b1;
        @(negedge clk);
        name_wr = 1'b0;
        cmp_word("name refused", {31'h0, refused}, {31'h0, name_inconsistent});
    endtask
    task automatic wait_state(input ush_meas_t st, input int bound);
        int i;
        for (i = 0; i < bound && measurement_state !== st; i++) @(negedge clk);
        if (i == bound) begin
            cmp_state(st);
            give_verdict();
        end
    endtask
    task automatic check_record(input logic [31:0] obs, input logic sym);
        logic [31:0] exp[RLEN];
        int          i;
        exp[0] = 32'h504E4E68;
        exp[1] = 32'h02000000;
        exp[2] = CTIME;
        exp[3] = PIDX;
        for (i = 4; i < 68; i++) exp[i] = SITE;
        exp[68] = NODE[47:16];
        exp[69] = {NODE[15:0], RPORT, 7'h00, sym};
        exp[70] = 32'h00000004;
        exp[71] = obs;
        exp[72] = 32'h00000400;
        for (i = 0; i < 256; i++) exp[73+i] = (sym && i == 0) ? 32'h0 : exp_hits[i];
        for (i = 0; i < 2000 && far.words.size() < RLEN; i++) @(negedge clk);
        if (i == 2000) begin
            cmp_word("record length", RLEN, far.words.size());
            give_verdict();
        end
        for (i = 0; i < RLEN; i++) begin
            cmp_word("record word", exp[i], far.words[i]);
        end
        cmp_word("last flag", 32'h1, {31'h0, far.lasts[RLEN-1]});
        far.words.delete();
        far.lasts.delete();
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        resetn = 1'b0;
        {enable_wr, enable_val, timeout_wr, name_wr, odd_symmetry} = 5'h00;
        timeout_val = 16'h0000;
        foreach (exp_hits[i]) exp_hits[i] = 32'h0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        cmp_word("timeout", 32'h708, {16'h0, timeout_rd});
        cmp_state(USH_IDLE);
        cmp_word("rec valid", 32'h0, {31'h0, rec_valid});
        $display("test reset values done");
        set_timeout(16'h0000);
        repeat (3) @(negedge clk);
        cmp_word("timeout", 32'h0, {16'h0, timeout_rd});
        cmp_state(USH_IDLE);
        $display("test timeout write done");
        set_enable(1'b1);
        cmp_word("enable", 32'h1, {31'h0, enable_rd});
        wait_state(USH_BUSY, 300);
        name_try(1'b1);
        far.send(8'h05, 3);
        far.send(8'h80, 7);
        exp_hits[5] = 32'h3;
        exp_hits[128] = 32'h7;
        repeat (500) @(negedge clk);
        cmp_state(USH_BUSY);
        set_enable(1'b0);
        cmp_state(USH_READY);
        cmp_word("enable", 32'h0, {31'h0, enable_rd});
        check_record(32'h0000000A, 1'b0);
        name_try(1'b0);
        $display("test manual stop done");
        odd_symmetry = 1'b1;
        exp_hits[5] = 32'h0;
        exp_hits[128] = 32'h0;
        set_timeout(16'h0014);
        set_enable(1'b1);
        wait_state(USH_BUSY, 300);
        far.send(8'h00, 5);
        far.send(8'h7F, 3);
        exp_hits[0] = 32'h5;
        exp_hits[127] = 32'h3;
        repeat (150) @(negedge clk);
        // reload near the end; without it expiry falls before the check
        set_timeout(16'h0014);
        repeat (100) @(negedge clk);
        cmp_state(USH_BUSY);
        wait_state(USH_READY, 800);
        cmp_word("enable", 32'h0, {31'h0, enable_rd});
        check_record(32'h00000008, 1'b1);
        $display("test timeout expiry done");
        odd_symmetry = 1'b0;
        exp_hits[0] = 32'h0;
        exp_hits[127] = 32'h0;
        set_timeout(16'h0000);
        set_enable(1'b1);
        wait_state(USH_BUSY, 300);
        // 65th sample trips the snapshot and is not counted
        far.send(8'h33, 65);
        exp_hits[51] = 32'h40;
        check_record(32'h00000040, 1'b0);
        cmp_state(USH_BUSY);
        $display("test snapshot done");
        give_verdict();
    end
endmodule
`default_nettype wire

/* File: bench/ush_engine_checker.sv */
// port assertions for the histogram engine
`default_nettype none
module ush_engine_checker
    import ush_pkg::*;
#(
    parameter int          BINS      = 256,
    parameter int          TICK_CYC  = 10,
    parameter logic [31:0] NEAR_FULL = 32'h00000040
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        enable_wr,
    input wire logic        enable_val,
    input wire logic        enable_rd,
    input wire logic        timeout_wr,
    input wire logic [15:0] timeout_val,
    input wire logic [15:0] timeout_rd,
    input wire ush_meas_t   measurement_state,
    input wire logic        result_ready,
    input wire logic        name_wr,
    input wire logic        name_wr_ok,
    input wire logic        name_inconsistent,
    input wire logic [31:0] rec_data,
    input wire logic        rec_last,
    input wire logic        rec_valid,
    input wire logic        rec_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_ready_mirror: assert property (result_ready == (measurement_state == USH_READY))
        else $error("result ready differs from state");
    chk_enable_mirror: assert property (enable_rd
        == (measurement_state inside {USH_CLEAR, USH_BUSY}))
        else $error("enable readback differs from state");
    chk_set_busy: assert property (enable_wr && enable_val
        && measurement_state inside {USH_IDLE, USH_READY} |=> enable_rd)
        else $error("enable set not taken");
    chk_clear_stops: assert property (enable_wr && !enable_val
        && measurement_state == USH_BUSY |=> result_ready && !enable_rd)
        else $error("enable clear did not stop");
    chk_timeout_load: assert property (timeout_wr |=> timeout_rd == $past(timeout_val))
        else $error("timeout readback wrong");
    chk_timeout_keep: assert property (!timeout_wr |=> $stable(timeout_rd))
        else $error("timeout changed without write");
    chk_name_refused: assert property (name_wr && enable_rd
        |=> name_inconsistent && !name_wr_ok)
        else $error("name change not refused");
    chk_name_taken: assert property (name_wr && !enable_rd
        |=> name_wr_ok && !name_inconsistent)
        else $error("name change not accepted");
    chk_clear_ends: assert property ($rose(measurement_state == USH_CLEAR)
        |-> ##[1:300] measurement_state == USH_BUSY)
        else $error("counter clear did not finish");
    chk_stop_record: assert property ($rose(result_ready) |-> ##[0:2] rec_valid)
        else $error("no record after stop");
    chk_word_hold: assert property (rec_valid && !rec_ready
        |=> rec_valid && $stable(rec_data) && $stable(rec_last))
        else $error("record word dropped under stall");
endmodule
bind ush_engine ush_engine_checker #(.BINS(BINS), .TICK_CYC(TICK_CYC), .NEAR_FULL(NEAR_FULL)) chk (
    .clk(clk), .resetn(resetn), .enable_wr(enable_wr), .enable_val(enable_val),
    .enable_rd(enable_rd), .timeout_wr(timeout_wr), .timeout_val(timeout_val),
    .timeout_rd(timeout_rd), .measurement_state(measurement_state),
    .result_ready(result_ready), .name_wr(name_wr), .name_wr_ok(name_wr_ok),
    .name_inconsistent(name_inconsistent), .rec_data(rec_data), .rec_last(rec_last),
    .rec_valid(rec_valid), .rec_ready(rec_ready));
`default_nettype wire

/* File: bench/ush_far_model.sv */
// sample source and stalling record sink
`default_nettype none
module ush_far_model (
    input  wire logic        clk,
    input  wire logic [31:0] rec_data,
    input  wire logic        rec_last,
    input  wire logic        rec_valid,
    output logic             rec_ready,
    output logic [7:0]       sample_msb,
    output logic             sample_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] words[$];
    logic        lasts[$];
    logic [2:0]  pace = 3'h0;
    initial begin
        rec_ready = 1'b0;
        sample_msb = 8'h00;
        sample_valid = 1'b0;
    end
    // ready low two cycles in eight
    always @(negedge clk) begin
        pace <= pace + 3'h1;
        rec_ready <= (pace > 3'h1);
    end
    always @(posedge clk) begin
        if (rec_valid && rec_ready) begin
            words.push_back(rec_data);
            lasts.push_back(rec_last);
        end
    end
    // idle line shows the inverse of the last sample
    task automatic send(input logic [7:0] bin, input int n);
        repeat (n) begin
            @(negedge clk);
            sample_msb = bin;
            sample_valid = 1'b1;
        end
        @(negedge clk);
        sample_valid = 1'b0;
        sample_msb = ~bin;
    endtask
endmodule
`default_nettype wire

/* File: logic/ush_defs.svh */
// constants for the upstream sample histogram engine
`ifndef USH_DEFS_SVH
`define USH_DEFS_SVH
`define USH_BINS            256
`define USH_CLK_HZ          100000000
`define USH_TIMEOUT_DEF     16'h0708
`define USH_FILE_TYPE       32'h504E4E68
`define USH_VER_MAJOR       8'h02
`define USH_VER_MINOR       8'h00
`define USH_NEAR_FULL       32'hFFFF0000
`define USH_CNT_MAX         32'hFFFFFFFF
`define USH_ID_BYTES        256
`define USH_NODE_BYTES      6
`endif

/* File: logic/ush_engine.sv */
// upstream sample histogram engine top
`default_nettype none
`include "ush_defs.svh"
module ush_engine
    import ush_pkg::*;
#(
    parameter int              BINS       = `USH_BINS,
    parameter int              TICK_CYC   = `USH_CLK_HZ,
    parameter logic [31:0]     NEAR_FULL  = `USH_NEAR_FULL
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic [7:0]    sample_msb,
    input  wire logic          sample_valid,
    input  wire logic          enable_wr,
    input  wire logic          enable_val,
    output logic               enable_rd,
    input  wire logic          timeout_wr,
    input  wire logic [15:0]   timeout_val,
    output logic [15:0]        timeout_rd,
    output ush_meas_t          measurement_state,
    output logic               result_ready,
    input  wire logic          name_wr,
    output logic               name_wr_ok,
    output logic               name_inconsistent,
    input  wire logic          odd_symmetry,
    input  wire logic [31:0]   capture_time,
    input  wire logic [31:0]   port_index,
    input  wire logic [47:0]   remote_phy_node,
    input  wire logic [7:0]    remote_port,
    input  wire logic [31:0]   site_id_word,
    output logic [31:0]        rec_data,
    output logic               rec_last,
    output logic               rec_valid,
    input  wire logic          rec_ready
);
    logic [31:0] hits [BINS];
    logic [31:0] snap [BINS];
    logic [31:0] observed;
    logic [31:0] snap_obs;
    logic        snap_odd;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic        vsync1;
    logic        vsync2;
    logic [7:0]  clr_idx;
    logic [15:0] countdown;
    logic        tick;
    logic        stop_req;
    logic        snap_req;
    logic        collecting;
    ush_rec_t    rec_st;
    logic [7:0]  rec_idx;
    logic [31:0] rec_word;
    logic        rec_wlast;
    logic        rec_go;
    ush_stream_if rs ();

    // samples arrive from the converter domain
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1  <= 8'h00;
            sync2  <= 8'h00;
            vsync1 <= 1'b0;
            vsync2 <= 1'b0;
        end else begin
            sync1  <= sample_msb;
            sync2  <= sync1;
            vsync1 <= sample_valid;
            vsync2 <= vsync1;
        end
    end

    assign collecting = (measurement_state == USH_BUSY);
    assign enable_rd  = (measurement_state == USH_CLEAR) || collecting;
    assign stop_req   = collecting && ((enable_wr && !enable_val)
                     || (observed == `USH_CNT_MAX)
                     || (tick && countdown == 16'h0001));
    assign snap_req   = collecting && vsync2 && (observed >= NEAR_FULL)
                     && (observed != `USH_CNT_MAX) && (timeout_rd == 16'h0000);

    ush_tick #(.CYCLES(TICK_CYC)) u_tick (
        .clk     (clk),
        .resetn  (resetn),
        .restart (!collecting),
        .tick    (tick)
    );

    // measurement state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            measurement_state <= USH_IDLE;
        end else begin
            unique case (measurement_state)
                USH_IDLE, USH_READY: begin
                    if (enable_wr && enable_val) begin
                        measurement_state <= USH_CLEAR;
                    end
                end
                USH_CLEAR: begin
                    if (enable_wr && !enable_val) begin
                        measurement_state <= USH_READY;
                    end else if (clr_idx == 8'(BINS - 1)) begin
                        measurement_state <= USH_BUSY;
                    end
                end
                USH_BUSY: begin
                    if (stop_req) begin
                        measurement_state <= USH_READY;
                    end
                end
            endcase
        end
    end
    assign result_ready = (measurement_state == USH_READY);

    // clear sweep index
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clr_idx <= 8'h00;
        end else if (measurement_state == USH_CLEAR) begin
            clr_idx <= clr_idx + 8'h01;
        end else begin
            clr_idx <= 8'h00;
        end
    end

    // hit and observed counters
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            observed <= 32'h0;
            for (int i = 0; i < BINS; i++) begin
                hits[i] <= 32'h0;
            end
        end else if (measurement_state == USH_CLEAR) begin
            hits[clr_idx] <= 32'h0;
            observed      <= 32'h0;
        end else if (snap_req) begin
            observed <= 32'h0;
            for (int i = 0; i < BINS; i++) begin
                hits[i] <= 32'h0;
            end
        end else if (collecting && vsync2 && !stop_req) begin
            observed        <= observed + 32'h1;
            hits[sync2]     <= hits[sync2] + 32'h1;
        end
    end

    // snapshot of the result set
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            snap_obs <= 32'h0;
            snap_odd <= 1'b0;
            for (int i = 0; i < BINS; i++) begin
                snap[i] <= 32'h0;
            end
        end else if (snap_req || stop_req) begin
            snap_obs <= observed;
            snap_odd <= odd_symmetry;
            for (int i = 0; i < BINS; i++) begin
                snap[i] <= hits[i];
            end
            if (odd_symmetry) begin
                snap[0] <= 32'h0;
            end
        end
    end

    // timeout setting and countdown
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timeout_rd <= `USH_TIMEOUT_DEF;
        end else if (timeout_wr) begin
            timeout_rd <= timeout_val;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            countdown <= `USH_TIMEOUT_DEF;
        end else if (timeout_wr) begin
            countdown <= timeout_val;
        end else if (!enable_rd) begin
            countdown <= timeout_rd;
        end else if (tick && countdown != 16'h0000) begin
            countdown <= countdown - 16'h0001;
        end
    end

    // result name guard
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            name_wr_ok        <= 1'b0;
            name_inconsistent <= 1'b0;
        end else begin
            name_wr_ok        <= name_wr && !enable_rd;
            name_inconsistent <= name_wr && enable_rd;
        end
    end

    // record emission
    always_comb begin
        rec_word  = 32'h0;
        rec_wlast = 1'b0;
        unique case (rec_st)
            USH_R_OFF:  rec_word = 32'h0;
            USH_R_TYPE: rec_word = `USH_FILE_TYPE;
            USH_R_VER:  rec_word = {`USH_VER_MAJOR, `USH_VER_MINOR, 16'h0000};
            USH_R_TIME: rec_word = capture_time;
            USH_R_PORT: rec_word = port_index;
            USH_R_ID:   rec_word = site_id_word;
            USH_R_NODE: rec_word = remote_phy_node[47:16];
            USH_R_TAIL: rec_word = {remote_phy_node[15:0], remote_port,
                                    7'h00, snap_odd};
            USH_R_OLEN: rec_word = 32'h4;
            USH_R_OBS:  rec_word = snap_obs;
            USH_R_HLEN: rec_word = 32'(BINS * 4);
            USH_R_HITS: begin
                rec_word  = snap[rec_idx];
                rec_wlast = (rec_idx == 8'(BINS - 1));
            end
            default:    rec_word = 32'h0;
        endcase
    end
    assign rs.data  = rec_word;
    assign rs.last  = rec_wlast;
    assign rs.valid = (rec_st != USH_R_OFF);
    assign rec_go   = rs.valid && rs.ready;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rec_st  <= USH_R_OFF;
            rec_idx <= 8'h00;
        end else if (rec_st == USH_R_OFF) begin
            rec_idx <= 8'h00;
            if (stop_req || snap_req) begin
                rec_st <= USH_R_TYPE;
            end
        end else if (rec_go) begin
            unique case (rec_st)
                USH_R_ID: begin
                    rec_idx <= rec_idx + 8'h01;
                    if (rec_idx == 8'(`USH_ID_BYTES / 4 - 1)) begin
                        rec_idx <= 8'h00;
                        rec_st  <= USH_R_NODE;
                    end
                end
                USH_R_HITS: begin
                    rec_idx <= rec_idx + 8'h01;
                    if (rec_wlast) begin
                        rec_st <= USH_R_OFF;
                    end
                end
                default: rec_st <= ush_rec_t'(rec_st + 4'h1);
            endcase
        end
    end

    ush_skid #(.W(33)) u_buf (
        .clk       (clk),
        .resetn    (resetn),
        .in_s      (rs),
        .out_data  (rec_data),
        .out_last  (rec_last),
        .out_valid (rec_valid),
        .out_ready (rec_ready)
    );
endmodule
`default_nettype wire

/* File: logic/ush_pkg.sv */
// types for the upstream sample histogram engine
`default_nettype none
package ush_pkg;
    typedef enum logic [1:0] {
        USH_IDLE,
        USH_CLEAR,
        USH_BUSY,
        USH_READY
    } ush_meas_t;
    typedef enum logic [3:0] {
        USH_R_OFF,
        USH_R_TYPE,
        USH_R_VER,
        USH_R_TIME,
        USH_R_PORT,
        USH_R_ID,
        USH_R_NODE,
        USH_R_TAIL,
        USH_R_OLEN,
        USH_R_OBS,
        USH_R_HLEN,
        USH_R_HITS
    } ush_rec_t;
endpackage
`default_nettype wire

/* File: logic/ush_skid.sv */
// two-entry buffer on the record word path
`default_nettype none
module ush_skid
    import ush_pkg::*;
#(
    parameter int W = 33
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    ush_stream_if.snk         in_s,
    output logic [W-2:0]      out_data,
    output logic              out_last,
    output logic              out_valid,
    input  wire logic         out_ready
);
    logic [W-1:0] mem [2];
    logic [1:0]   cnt;
    logic         rd;
    logic         wr_ptr;
    logic         rd_ptr;
    logic         push;
    logic         pop;
    assign in_s.ready = (cnt != 2'h2);
    assign push      = in_s.valid && in_s.ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (cnt != 2'h0);
    assign out_data  = mem[rd_ptr][W-2:0];
    assign out_last  = mem[rd_ptr][W-1];
    assign rd        = pop;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem[0] <= '0;
            mem[1] <= '0;
        end else if (push) begin
            mem[wr_ptr] <= {in_s.last, in_s.data};
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt    <= 2'h0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
        end else begin
            cnt    <= cnt + {1'b0, push} - {1'b0, rd};
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ rd;
        end
    end
endmodule
`default_nettype wire

/* File: logic/ush_stream_if.sv */
// word stream carrier between record builder and output buffer
`default_nettype none
interface ush_stream_if;
    logic [31:0] data;
    logic        last;
    logic        valid;
    logic        ready;
    modport src (output data, output last, output valid, input ready);
    modport snk (input data, input last, input valid, output ready);
endinterface
`default_nettype wire

/* File: logic/ush_tick.sv */
// one-second tick divider from the sample clock
`default_nettype none
`include "ush_defs.svh"
module ush_tick
    import ush_pkg::*;
#(
    parameter int CYCLES = `USH_CLK_HZ
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic restart,
    output logic      tick
);
    logic [31:0] cnt;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt  <= 32'h0;
            tick <= 1'b0;
        end else if (restart) begin
            cnt  <= 32'h0;
            tick <= 1'b0;
        end else if (cnt == 32'(CYCLES - 1)) begin
            cnt  <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire
